// >>> iomad_pkg.sv
package iomad_pkg;
    // cycle sources
    typedef enum logic [1:0] {
        IOMAD_SRC_HUB_IO,
        IOMAD_SRC_HUB_MEM,
        IOMAD_SRC_PCI_IO,
        IOMAD_SRC_PCI_MEM
    } iomad_src_t;

    // routing targets
    typedef enum logic [3:0] {
        IOMAD_TGT_PCI,
        IOMAD_TGT_LPC,
        IOMAD_TGT_FIRMWARE_HUB,
        IOMAD_TGT_MAIN_MEMORY,
        IOMAD_TGT_IOAPIC,
        IOMAD_TGT_DISK,
        IOMAD_TGT_POWER_MGMT,
        IOMAD_TGT_HEALTH_TIMER,
        IOMAD_TGT_AUDIO,
        IOMAD_TGT_NETWORK,
        IOMAD_TGT_HUB,
        IOMAD_TGT_NONE,
        IOMAD_TGT_FIXED
    } iomad_tgt_t;

    // decode speed
    typedef enum logic [1:0] {
        IOMAD_SPEED_NONE,
        IOMAD_SPEED_FAST,
        IOMAD_SPEED_MEDIUM,
        IOMAD_SPEED_SUBTRACTIVE
    } iomad_speed_t;

    localparam int IOMAD_IO_AW  = 16;
    localparam int IOMAD_MEM_AW = 32;

    // range sizes, as log2 of bytes
    localparam int IOMAD_PM_LOG2      = 6;
    localparam int IOMAD_MIXER_LOG2   = 8;
    localparam int IOMAD_GEN1_LOG2    = 7;
    localparam int IOMAD_HEALTH_LOG2  = 5;
    localparam int IOMAD_LEGACY_LOG2  = 3;
    localparam int IOMAD_MIDI_LOG2    = 1;
    localparam int IOMAD_MON_LOG2     = 4;
    localparam int IOMAD_NET_LOG2     = 12;
    localparam int IOMAD_DISKX_LOG2   = 10;

    localparam logic [15:0] IOMAD_HEALTH_OFFSET = 16'h0060;

    // legacy disk ports and port F0
    localparam logic [15:0] IOMAD_PRI_CMD_BASE  = 16'h01F0;
    localparam logic [15:0] IOMAD_SEC_CMD_BASE  = 16'h0170;
    localparam logic [15:0] IOMAD_PRI_CTL_PORT  = 16'h03F6;
    localparam logic [15:0] IOMAD_SEC_CTL_PORT  = 16'h0376;
    localparam logic [15:0] IOMAD_F0_PORT       = 16'h00F0;

    // selectable legacy bases
    localparam logic [15:0] IOMAD_PAR_BASES [3] = '{16'h0378, 16'h0278, 16'h03BC};
    localparam logic [15:0] IOMAD_SER_BASES [8] = '{16'h03F8, 16'h02F8, 16'h0220, 16'h0228,
                                                   16'h0238, 16'h02E8, 16'h0338, 16'h03E8};
    localparam logic [15:0] IOMAD_FDC_BASES [2] = '{16'h03F0, 16'h0370};
    localparam logic [15:0] IOMAD_MIDI_BASES [4] = '{16'h0330, 16'h0300, 16'h0310, 16'h0320};

    // memory map
    localparam logic [31:0] IOMAD_LOW_MEM_TOP    = 32'h000D_FFFF;
    localparam logic [31:0] IOMAD_BIOS_LO        = 32'h000E_0000;
    localparam logic [31:0] IOMAD_BIOS_HI        = 32'h000F_FFFF;
    localparam logic [31:0] IOMAD_HIGH_MEM_BASE  = 32'h0010_0000;
    localparam logic [31:0] IOMAD_IOAPIC_LO      = 32'hFEC0_0000;
    localparam logic [31:0] IOMAD_IOAPIC_HI      = 32'hFEC0_0100;
    localparam logic [12:0] IOMAD_FW1_TOP9       = 13'h1FF8;
    localparam logic [8:0]  IOMAD_FW1_HI_SEL     = 9'h1FF;
    localparam logic [8:0]  IOMAD_FW1_LO_SEL     = 9'h1FF;
    localparam logic [9:0]  IOMAD_FW1_HI_PREFIX  = 10'h3FF;
    localparam logic [9:0]  IOMAD_FW1_LO_PREFIX  = 10'h3FE;
    localparam logic [7:0]  IOMAD_FW2_HI_PREFIX  = 8'hFF;
    localparam int          IOMAD_FW_BIOS_BIT    = 7;
    localparam int          IOMAD_FW_TOP_IDX     = 7;
endpackage

// >>> iomad_range_match.sv
`timescale 1ns/1ps
`default_nettype none
// matches an address against a size-aligned base
module iomad_range_match #(
    parameter int AW   = 16,
    parameter int LOG2 = 3
) (
    input  wire logic [AW-1:0] addr_in,
    input  wire logic [AW-1:0] base_in,
    input  wire logic          enable_in,
    output logic               hit_out
);
    assign hit_out = enable_in && (addr_in[AW-1:LOG2] == base_in[AW-1:LOG2]);
endmodule
`default_nettype wire

// >>> iomad_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module iomad_decoder
    import iomad_pkg::*;
(
    input  wire logic                    mclk_in,
    input  wire logic                    reset_in,
    input  wire logic                    cyc_valid_in,
    input  wire iomad_pkg::iomad_src_t   cyc_src_in,
    input  wire logic [31:0]             cyc_addr_in,
    input  wire logic                    cyc_write_in,
    input  wire logic                    cyc_lock_in,
    input  wire logic                    fixed_io_hit_in,
    input  wire logic                    pri_io_enable_in,
    input  wire logic                    sec_io_enable_in,
    input  wire logic                    disk_legacy_mode_in,
    input  wire logic                    f0_read_positive_decode_enable_in,
    input  wire logic                    pm_enable_in,
    input  wire logic [15:0]             pm_base_in,
    input  wire logic                    health_enable_in,
    input  wire logic                    audio_mixer_enable_in,
    input  wire logic [15:0]             audio_mixer_base_in,
    input  wire logic                    modem_mixer_enable_in,
    input  wire logic [15:0]             modem_mixer_base_in,
    input  wire logic                    lpc_gen1_enable_in,
    input  wire logic [15:0]             lpc_gen1_base_in,
    input  wire logic                    par_enable_in,
    input  wire logic [1:0]              par_sel_in,
    input  wire logic                    ser1_enable_in,
    input  wire logic [2:0]              ser1_sel_in,
    input  wire logic                    ser2_enable_in,
    input  wire logic [2:0]              ser2_sel_in,
    input  wire logic                    fdc_enable_in,
    input  wire logic                    fdc_sel_in,
    input  wire logic                    midi_enable_in,
    input  wire logic [1:0]              midi_sel_in,
    input  wire logic                    mon_enable_in,
    input  wire logic [15:0]             mon_base_in,
    input  wire logic                    mon_trap_in,
    input  wire logic                    subtractive_enable_in,
    input  wire logic [7:0]              fw_decode_enable_in,
    input  wire logic [3:0]              fw_decode_enable2_in,
    input  wire logic [31:0]             top_of_memory_limit_in,
    input  wire logic                    net_enable_in,
    input  wire logic [31:0]             net_base_in,
    input  wire logic                    diskx_enable_in,
    input  wire logic                    diskx_io_cfg_in,
    input  wire logic [31:0]             diskx_base_in,
    input  wire logic                    peer_range_hit_in,
    output logic                         route_valid_out,
    output iomad_pkg::iomad_tgt_t        route_target_out,
    output iomad_pkg::iomad_speed_t      route_speed_out,
    output logic                         route_lock_honoured_out,
    output logic                         route_trap_out,
    output logic                         route_on_pci_out
);
    import iomad_pkg::*;

    wire logic [15:0] io_addr     = cyc_addr_in[15:0];
    wire logic        is_io       = (cyc_src_in == IOMAD_SRC_HUB_IO) ||
                                    (cyc_src_in == IOMAD_SRC_PCI_IO);
    wire logic        from_hub    = (cyc_src_in == IOMAD_SRC_HUB_IO) ||
                                    (cyc_src_in == IOMAD_SRC_HUB_MEM);
    wire logic        io_upper_zero = (cyc_addr_in[31:16] == 16'h0000);

    // legacy disk ports and port F0 read
    wire logic pri_port = (io_addr[15:3] == IOMAD_PRI_CMD_BASE[15:3]) ||
                          (io_addr == IOMAD_PRI_CTL_PORT);
    wire logic sec_port = (io_addr[15:3] == IOMAD_SEC_CMD_BASE[15:3]) ||
                          (io_addr == IOMAD_SEC_CTL_PORT);

    wire logic pri_claim = pri_port && pri_io_enable_in && disk_legacy_mode_in;
    wire logic sec_claim = sec_port && sec_io_enable_in && disk_legacy_mode_in;
    wire logic f0_read   = (io_addr == IOMAD_F0_PORT) && !cyc_write_in;

    // relocatable ranges
    wire logic [15:0] health_base = 16'(pm_base_in + IOMAD_HEALTH_OFFSET);
    logic hit_pm;
    logic hit_health;
    logic hit_amix;
    logic hit_mmix;
    logic hit_gen1;
    logic hit_mon;
    logic hit_par;
    logic hit_ser1;
    logic hit_ser2;
    logic hit_fdc;
    logic hit_midi;
    logic hit_net;
    logic hit_diskx;

    iomad_range_match #(.AW(IOMAD_IO_AW), .LOG2(IOMAD_PM_LOG2)) u_pm (
        .addr_in(io_addr),
        .base_in(pm_base_in),
        .enable_in(pm_enable_in),
        .hit_out(hit_pm));

    iomad_range_match #(.AW(IOMAD_IO_AW), .LOG2(IOMAD_HEALTH_LOG2)) u_health (
        .addr_in(io_addr),
        .base_in(health_base),
        .enable_in(health_enable_in),
        .hit_out(hit_health));

    iomad_range_match #(.AW(IOMAD_IO_AW), .LOG2(IOMAD_MIXER_LOG2)) u_amix (
        .addr_in(io_addr), .base_in(audio_mixer_base_in),
        .enable_in(audio_mixer_enable_in), .hit_out(hit_amix));
    iomad_range_match #(.AW(IOMAD_IO_AW), .LOG2(IOMAD_MIXER_LOG2)) u_mmix (
        .addr_in(io_addr), .base_in(modem_mixer_base_in),
        .enable_in(modem_mixer_enable_in), .hit_out(hit_mmix));
    iomad_range_match #(.AW(IOMAD_IO_AW), .LOG2(IOMAD_GEN1_LOG2)) u_gen1 (
        .addr_in(io_addr), .base_in(lpc_gen1_base_in),
        .enable_in(lpc_gen1_enable_in), .hit_out(hit_gen1));
    iomad_range_match #(.AW(IOMAD_IO_AW), .LOG2(IOMAD_MON_LOG2)) u_mon (
        .addr_in(io_addr), .base_in(mon_base_in), .enable_in(mon_enable_in),
        .hit_out(hit_mon));

    // selected legacy bases; unused parallel code 3 never matches
    wire logic par_sel_ok = (par_sel_in != 2'b11);
    iomad_range_match #(.AW(IOMAD_IO_AW), .LOG2(IOMAD_LEGACY_LOG2)) u_par (
        .addr_in(io_addr),
        .base_in(IOMAD_PAR_BASES[par_sel_ok ? par_sel_in : 2'b00]),
        .enable_in(par_enable_in && par_sel_ok),
        .hit_out(hit_par));

    iomad_range_match #(.AW(IOMAD_IO_AW), .LOG2(IOMAD_LEGACY_LOG2)) u_ser1 (
        .addr_in(io_addr),
        .base_in(IOMAD_SER_BASES[ser1_sel_in]),
        .enable_in(ser1_enable_in),
        .hit_out(hit_ser1));

    iomad_range_match #(.AW(IOMAD_IO_AW), .LOG2(IOMAD_LEGACY_LOG2)) u_ser2 (
        .addr_in(io_addr),
        .base_in(IOMAD_SER_BASES[ser2_sel_in]),
        .enable_in(ser2_enable_in),
        .hit_out(hit_ser2));

    iomad_range_match #(.AW(IOMAD_IO_AW), .LOG2(IOMAD_LEGACY_LOG2)) u_fdc (
        .addr_in(io_addr),
        .base_in(IOMAD_FDC_BASES[fdc_sel_in]),
        .enable_in(fdc_enable_in),
        .hit_out(hit_fdc));

    iomad_range_match #(.AW(IOMAD_IO_AW), .LOG2(IOMAD_MIDI_LOG2)) u_midi (
        .addr_in(io_addr),
        .base_in(IOMAD_MIDI_BASES[midi_sel_in]),
        .enable_in(midi_enable_in),
        .hit_out(hit_midi));

    wire logic lpc_var_hit = hit_gen1 || hit_par || hit_ser1 || hit_ser2 ||
                             hit_fdc || hit_midi || (hit_mon && !mon_trap_in);

    // memory windows
    iomad_range_match #(.AW(IOMAD_MEM_AW), .LOG2(IOMAD_NET_LOG2)) u_net (
        .addr_in(cyc_addr_in),
        .base_in(net_base_in),
        .enable_in(net_enable_in),
        .hit_out(hit_net));

    iomad_range_match #(.AW(IOMAD_MEM_AW), .LOG2(IOMAD_DISKX_LOG2)) u_diskx (
        .addr_in(cyc_addr_in),
        .base_in(diskx_base_in),
        .enable_in(diskx_enable_in && diskx_io_cfg_in),
        .hit_out(hit_diskx));

    wire logic mem_main = (cyc_addr_in <= IOMAD_LOW_MEM_TOP) ||
                          ((cyc_addr_in >= IOMAD_HIGH_MEM_BASE) &&
                           (cyc_addr_in <= top_of_memory_limit_in));

    wire logic mem_bios = (cyc_addr_in >= IOMAD_BIOS_LO) &&
                          (cyc_addr_in <= IOMAD_BIOS_HI) &&
                          fw_decode_enable_in[IOMAD_FW_BIOS_BIT];

    wire logic mem_apic = (cyc_addr_in >= IOMAD_IOAPIC_LO) &&
                          (cyc_addr_in <= IOMAD_IOAPIC_HI);

    // 512 KB windows: bits 31:22 pick upper or alias half, 21:19 the window
    wire logic       fw1_zone = (cyc_addr_in[31:22] == IOMAD_FW1_HI_PREFIX) ||
                                (cyc_addr_in[31:22] == IOMAD_FW1_LO_PREFIX);
    wire logic [2:0] fw1_idx  = cyc_addr_in[21:19];
    wire logic       fw1_hit  = fw1_zone &&
                                ((fw1_idx == 3'(IOMAD_FW_TOP_IDX)) ||
                                 fw_decode_enable_in[fw1_idx]);

    // 1 MB windows FF40-FF7F and aliases FF00-FF3F
    wire logic       fw2_zone = (cyc_addr_in[31:24] == IOMAD_FW2_HI_PREFIX) &&
                                !cyc_addr_in[23];
    wire logic [1:0] fw2_idx  = cyc_addr_in[21:20];
    wire logic       fw2_hit  = fw2_zone && fw_decode_enable2_in[fw2_idx];
    wire logic       mem_fw   = mem_bios || fw1_hit || fw2_hit;

    // route selection
    iomad_tgt_t   tgt_nxt;
    iomad_speed_t speed_nxt;
    logic         lock_nxt;
    logic         trap_nxt;
    logic         on_pci_nxt;

    always_comb begin
        tgt_nxt    = IOMAD_TGT_PCI;
        speed_nxt  = IOMAD_SPEED_NONE;
        lock_nxt   = cyc_lock_in;
        trap_nxt   = 1'b0;
        on_pci_nxt = from_hub;
        unique case (cyc_src_in)
            IOMAD_SRC_HUB_IO, IOMAD_SRC_PCI_IO: begin
                speed_nxt = from_hub ? IOMAD_SPEED_FAST : IOMAD_SPEED_MEDIUM;
                if (!io_upper_zero) begin
                    tgt_nxt   = from_hub ? IOMAD_TGT_PCI : IOMAD_TGT_NONE;
                    speed_nxt = IOMAD_SPEED_NONE;
                end else if (f0_read) begin
                    if (f0_read_positive_decode_enable_in) begin
                        tgt_nxt   = from_hub ? IOMAD_TGT_PCI : IOMAD_TGT_NONE;
                        speed_nxt = IOMAD_SPEED_NONE;
                    end else begin
                        tgt_nxt = IOMAD_TGT_LPC;
                    end
                end else if (pri_port || sec_port) begin
                    if (pri_claim || sec_claim) begin
                        tgt_nxt = IOMAD_TGT_DISK;
                    end else begin
                        tgt_nxt   = from_hub ? IOMAD_TGT_PCI : IOMAD_TGT_NONE;
                        speed_nxt = IOMAD_SPEED_NONE;
                    end
                end else if (fixed_io_hit_in) begin
                    tgt_nxt = IOMAD_TGT_FIXED;
                end else if (hit_health) begin
                    tgt_nxt = IOMAD_TGT_HEALTH_TIMER;
                end else if (hit_pm) begin
                    tgt_nxt = IOMAD_TGT_POWER_MGMT;
                end else if (hit_amix || hit_mmix) begin
                    tgt_nxt = IOMAD_TGT_AUDIO;
                end else if (lpc_var_hit) begin
                    tgt_nxt = IOMAD_TGT_LPC;
                end else if (hit_mon) begin
                    tgt_nxt  = IOMAD_TGT_PCI;
                    trap_nxt = 1'b1;
                end else begin
                    tgt_nxt   = from_hub ? IOMAD_TGT_PCI : IOMAD_TGT_NONE;
                    speed_nxt = IOMAD_SPEED_NONE;
                end
                on_pci_nxt = from_hub && (tgt_nxt == IOMAD_TGT_PCI);
            end

            IOMAD_SRC_HUB_MEM: begin
                speed_nxt  = IOMAD_SPEED_FAST;
                on_pci_nxt = 1'b0;
                if (mem_main) begin
                    tgt_nxt = IOMAD_TGT_MAIN_MEMORY;
                end else if (hit_net) begin
                    tgt_nxt = IOMAD_TGT_NETWORK;
                end else if (hit_diskx) begin
                    tgt_nxt  = IOMAD_TGT_DISK;
                    lock_nxt = 1'b0;
                end else begin
                    // driven on PCI, then reclaimed
                    on_pci_nxt = 1'b1;
                    speed_nxt  = IOMAD_SPEED_MEDIUM;
                    if (mem_apic) begin
                        tgt_nxt = IOMAD_TGT_IOAPIC;
                    end else if (mem_fw) begin
                        tgt_nxt = IOMAD_TGT_FIRMWARE_HUB;
                    end else if (subtractive_enable_in) begin
                        tgt_nxt   = IOMAD_TGT_LPC;
                        speed_nxt = IOMAD_SPEED_SUBTRACTIVE;
                    end else begin
                        tgt_nxt   = IOMAD_TGT_PCI;
                        speed_nxt = IOMAD_SPEED_NONE;
                    end
                end
            end

            IOMAD_SRC_PCI_MEM: begin
                on_pci_nxt = 1'b0;
                speed_nxt  = IOMAD_SPEED_MEDIUM;
                if (peer_range_hit_in) begin
                    tgt_nxt   = IOMAD_TGT_NONE;
                    speed_nxt = IOMAD_SPEED_NONE;
                end else if (mem_apic) begin
                    tgt_nxt = IOMAD_TGT_IOAPIC;
                end else if (mem_fw) begin
                    tgt_nxt = IOMAD_TGT_FIRMWARE_HUB;
                end else begin
                    // direct windows invisible here, go up
                    tgt_nxt = IOMAD_TGT_HUB;
                end
            end
        endcase
    end

    logic         valid_r;
    iomad_tgt_t   tgt_r;
    iomad_speed_t speed_r;
    logic         lock_r;
    logic         trap_r;
    logic         on_pci_r;

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            valid_r  <= 1'b0;
            tgt_r    <= IOMAD_TGT_NONE;
            speed_r  <= IOMAD_SPEED_NONE;
            lock_r   <= 1'b0;
            trap_r   <= 1'b0;
            on_pci_r <= 1'b0;
        end else begin
            valid_r <= cyc_valid_in;
            if (cyc_valid_in) begin
                tgt_r    <= tgt_nxt;
                speed_r  <= speed_nxt;
                lock_r   <= lock_nxt;
                trap_r   <= trap_nxt;
                on_pci_r <= on_pci_nxt;
            end
        end
    end

    assign route_valid_out         = valid_r;
    assign route_target_out        = tgt_r;
    assign route_speed_out         = speed_r;
    assign route_lock_honoured_out = lock_r;
    assign route_trap_out          = trap_r;
    assign route_on_pci_out        = on_pci_r;
endmodule
`default_nettype wire

// >>> iomad_decoder_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module iomad_decoder_assertions (
    input  wire logic                   mclk_in,
    input  wire logic                   reset_in,
    input  wire logic                   cyc_valid_in,
    input  wire iomad_pkg::iomad_src_t  cyc_src_in,
    input  wire logic [31:0]            cyc_addr_in,
    input  wire logic                   cyc_write_in,
    input  wire logic                   fixed_io_hit_in,
    input  wire logic                   f0_read_positive_decode_enable_in,
    input  wire logic [7:0]             fw_decode_enable_in,
    input  wire logic                   peer_range_hit_in,
    input  wire logic                   route_valid_out,
    input  wire iomad_pkg::iomad_tgt_t  route_target_out,
    input  wire iomad_pkg::iomad_speed_t route_speed_out,
    input  wire logic                   route_lock_honoured_out,
    input  wire logic                   route_trap_out
);
    import iomad_pkg::*;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    wire logic hub_mem = cyc_valid_in && cyc_src_in == IOMAD_SRC_HUB_MEM;
    wire logic pci_mem = cyc_valid_in && cyc_src_in == IOMAD_SRC_PCI_MEM && !peer_range_hit_in;
    wire logic hub_io  = cyc_valid_in && cyc_src_in == IOMAD_SRC_HUB_IO;
    apic_claim_a:
    assert property (pci_mem && cyc_addr_in >= IOMAD_IOAPIC_LO && cyc_addr_in <= IOMAD_IOAPIC_HI
        |=> route_target_out == IOMAD_TGT_IOAPIC) else $error("apic window missed");
    low_memory_a:
    assert property (hub_mem && cyc_addr_in <= IOMAD_LOW_MEM_TOP
        |=> route_target_out == IOMAD_TGT_MAIN_MEMORY) else $error("low memory not main");
    bios_gate_a:
    assert property (hub_mem && cyc_addr_in >= IOMAD_BIOS_LO && cyc_addr_in <= IOMAD_BIOS_HI
        && !fw_decode_enable_in[IOMAD_FW_BIOS_BIT]
        |=> route_target_out != IOMAD_TGT_FIRMWARE_HUB) else $error("bios window not gated");
    top_window_a:
    assert property (pci_mem && cyc_addr_in[31:19] inside {13'h1FFF, 13'h1FF7}
        |=> route_target_out == IOMAD_TGT_FIRMWARE_HUB) else $error("top window missed");
    fw_window_a:
    assert property (pci_mem && cyc_addr_in[31:23] == 9'h1FF
        && fw_decode_enable_in[cyc_addr_in[21:19]]
        |=> route_target_out == IOMAD_TGT_FIRMWARE_HUB) else $error("enabled window missed");
    diskx_lock_a:
    assert property (route_valid_out && route_target_out == IOMAD_TGT_DISK
        && $past(cyc_src_in) == IOMAD_SRC_HUB_MEM |-> !route_lock_honoured_out)
        else $error("lock honoured in disk window");
    pci_fixed_a:
    assert property (cyc_valid_in && cyc_src_in == IOMAD_SRC_PCI_IO && fixed_io_hit_in
        && cyc_addr_in[31:16] == 16'h0000 |=> route_speed_out == IOMAD_SPEED_MEDIUM)
        else $error("fixed range not medium speed");
    f0_read_a:
    assert property (hub_io && cyc_addr_in == 32'h0000_00F0 && !cyc_write_in
        && !f0_read_positive_decode_enable_in ##1 route_valid_out
        |-> route_target_out == IOMAD_TGT_LPC) else $error("f0 read not on lpc");
    cover property (hub_mem ##1 route_target_out == IOMAD_TGT_DISK);
    cover property (route_valid_out && route_speed_out == IOMAD_SPEED_SUBTRACTIVE);
    cover property (route_valid_out && route_trap_out);
endmodule
`default_nettype wire

// >>> iomad_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host and pci master: one-cycle strobe, address not held when idle
module iomad_host_model (
    input  wire logic                  mclk_in,
    input  wire logic                  go_in,
    input  wire iomad_pkg::iomad_src_t src_in,
    input  wire logic [31:0]           addr_in,
    input  wire logic                  wr_in,
    input  wire logic                  lk_in,
    output logic                       cyc_valid_out = 1'b0,
    output iomad_pkg::iomad_src_t      cyc_src_out = iomad_pkg::IOMAD_SRC_HUB_IO,
    output logic [31:0]                cyc_addr_out = 32'h0000_0000,
    output logic                       cyc_write_out = 1'b0,
    output logic                       cyc_lock_out = 1'b0
);
    always @(posedge mclk_in) begin
        cyc_valid_out <= go_in;
        cyc_src_out <= src_in;
        cyc_addr_out <= go_in ? addr_in : ~cyc_addr_out;
        cyc_write_out <= go_in ? wr_in : ~cyc_write_out;
        cyc_lock_out <= go_in ? lk_in : 1'b0;
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import iomad_pkg::*;
    localparam iomad_src_t HI = IOMAD_SRC_HUB_IO, HM = IOMAD_SRC_HUB_MEM;
    localparam iomad_src_t PI = IOMAD_SRC_PCI_IO, PM = IOMAD_SRC_PCI_MEM;
    logic mclk_in = 1'b0, reset_in = 1'b1, go = 1'b0, req_wr = 1'b0, req_lk = 1'b0;
    iomad_src_t req_src = HI;
    logic [31:0] req_addr = 32'h0000_0000;
    int err_total = 0, cmp_count = 0;
    logic cyc_valid_in, cyc_write_in, cyc_lock_in, fixed_io_hit_in = 1'b0;
    iomad_src_t cyc_src_in;
    logic [31:0] cyc_addr_in;
    logic pri_io_enable_in = 1'b1, sec_io_enable_in = 1'b1, disk_legacy_mode_in = 1'b1;
    logic f0_read_positive_decode_enable_in = 1'b0, subtractive_enable_in = 1'b0;
    logic pm_enable_in = 1'b1, health_enable_in = 1'b1, audio_mixer_enable_in = 1'b1;
    logic modem_mixer_enable_in = 1'b1, lpc_gen1_enable_in = 1'b1, par_enable_in = 1'b1;
    logic ser1_enable_in = 1'b1, ser2_enable_in = 1'b1, fdc_enable_in = 1'b1, fdc_sel_in = 1'b0;
    logic midi_enable_in = 1'b1, mon_enable_in = 1'b1, mon_trap_in = 1'b1, net_enable_in = 1'b1;
    logic diskx_enable_in = 1'b1, diskx_io_cfg_in = 1'b1, peer_range_hit_in = 1'b0;
    // bases kept apart from each other and the fixed ports
    logic [15:0] pm_base_in = 16'h0400, audio_mixer_base_in = 16'h0500;
    logic [15:0] modem_mixer_base_in = 16'h0600, lpc_gen1_base_in = 16'h0700;
    logic [15:0] mon_base_in = 16'h0800;
    logic [1:0] par_sel_in = 2'h0, midi_sel_in = 2'h2;
    logic [2:0] ser1_sel_in = 3'h1, ser2_sel_in = 3'h7;
    logic [7:0] fw_decode_enable_in = 8'h01;
    logic [3:0] fw_decode_enable2_in = 4'h8;
    logic [31:0] top_of_memory_limit_in = 32'h0800_0000;
    logic [31:0] net_base_in = 32'h9000_0000, diskx_base_in = 32'h9100_0000;
    logic route_valid_out, route_lock_honoured_out, route_trap_out, route_on_pci_out;
    iomad_tgt_t route_target_out;
    iomad_speed_t route_speed_out;
    always #12.5 mclk_in = ~mclk_in;
    iomad_host_model host (.mclk_in(mclk_in), .go_in(go), .src_in(req_src), .addr_in(req_addr),
        .wr_in(req_wr), .lk_in(req_lk), .cyc_valid_out(cyc_valid_in), .cyc_src_out(cyc_src_in),
        .cyc_addr_out(cyc_addr_in), .cyc_write_out(cyc_write_in), .cyc_lock_out(cyc_lock_in));
    iomad_decoder uut (.*);
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic ck(input iomad_src_t s, input logic [31:0] a, input iomad_tgt_t t,
                      input logic lk = 1'b0);
        int n = 0;
        go <= 1'b1;
        req_src <= s;
        req_addr <= a;
        req_lk <= lk;
        @(posedge mclk_in);
        go <= 1'b0;
        do begin
            @(posedge mclk_in);
            #1;
            n++;
        end while (route_valid_out !== 1'b1 && n < 4);
        cmp("valid", 32'h0000_0001, 32'(route_valid_out));
        cmp("target", 32'(t), 32'(route_target_out));
        cmp("lock", 32'(lk && t != IOMAD_TGT_DISK), 32'(route_lock_honoured_out));
        @(posedge mclk_in);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge mclk_in);
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge mclk_in);
        reset_in <= 1'b0;
        ck(HI, 16'h01F7, IOMAD_TGT_DISK);
        ck(HI, 16'h0170, IOMAD_TGT_DISK);
        ck(HI, 16'h00F0, IOMAD_TGT_LPC);
        ck(HI, 16'h043F, IOMAD_TGT_POWER_MGMT);
        ck(HI, 16'h0440, IOMAD_TGT_PCI);
        ck(HI, 16'h0460, IOMAD_TGT_HEALTH_TIMER);
        cmp("speed", 32'(IOMAD_SPEED_FAST), 32'(route_speed_out));
        ck(HI, 16'h047F, IOMAD_TGT_HEALTH_TIMER);
        ck(HI, 16'h0480, IOMAD_TGT_PCI);
        ck(HI, 16'h05FF, IOMAD_TGT_AUDIO);
        ck(HI, 16'h077F, IOMAD_TGT_LPC);
        ck(HI, 16'h0780, IOMAD_TGT_PCI);
        ck(HI, 16'h037F, IOMAD_TGT_LPC);
        ck(HI, 16'h02F8, IOMAD_TGT_LPC);
        ck(HI, 16'h03EF, IOMAD_TGT_LPC);
        ck(HI, 16'h0311, IOMAD_TGT_LPC);
        ck(HI, 16'h0312, IOMAD_TGT_PCI);
        ck(HI, 16'h080F, IOMAD_TGT_PCI);
        cmp("trap", 32'h0000_0001, 32'(route_trap_out));
        ck(HM, 32'h000D_FFFF, IOMAD_TGT_MAIN_MEMORY);
        ck(HM, 32'h0400_0000, IOMAD_TGT_MAIN_MEMORY);
        ck(HM, 32'h000E_0000, IOMAD_TGT_PCI);
        ck(HM, 32'hFEC0_0100, IOMAD_TGT_IOAPIC);
        cmp("on_pci", 32'h0000_0001, 32'(route_on_pci_out));
        ck(HM, 32'hFF87_FFFF, IOMAD_TGT_FIRMWARE_HUB);
        ck(HM, 32'hFFC8_0000, IOMAD_TGT_PCI);
        ck(HM, 32'hFFB8_0000, IOMAD_TGT_FIRMWARE_HUB);
        ck(HM, 32'hFFFF_FFFF, IOMAD_TGT_FIRMWARE_HUB);
        ck(HM, 32'hFF30_0000, IOMAD_TGT_FIRMWARE_HUB);
        ck(HM, 32'hFF40_0000, IOMAD_TGT_PCI);
        ck(HM, 32'h9000_0FFF, IOMAD_TGT_NETWORK);
        cmp("on_pci", 32'h0000_0000, 32'(route_on_pci_out));
        ck(HM, 32'h9000_1000, IOMAD_TGT_PCI);
        ck(HM, 32'h9100_03FF, IOMAD_TGT_DISK, 1'b1);
        ck(HM, 32'h9100_0400, IOMAD_TGT_PCI);
        ck(PM, 32'h9000_0000, IOMAD_TGT_HUB);
        ck(PM, 32'hFEC0_0000, IOMAD_TGT_IOAPIC);
        ck(PM, 32'h8000_0000, IOMAD_TGT_HUB, 1'b1);
        $display("decode map test done");
        pri_io_enable_in <= 1'b0;
        ck(HI, 16'h01F0, IOMAD_TGT_PCI);
        disk_legacy_mode_in <= 1'b0;
        ck(HI, 16'h0170, IOMAD_TGT_PCI);
        f0_read_positive_decode_enable_in <= 1'b1;
        ck(HI, 16'h00F0, IOMAD_TGT_PCI);
        fw_decode_enable_in <= 8'h82;
        ck(HM, 32'h000F_FFFF, IOMAD_TGT_FIRMWARE_HUB);
        ck(HM, 32'hFF88_0000, IOMAD_TGT_FIRMWARE_HUB);
        ck(HM, 32'hFFC0_0000, IOMAD_TGT_PCI);
        subtractive_enable_in <= 1'b1;
        mon_trap_in <= 1'b0;
        ck(HM, 32'h8000_0000, IOMAD_TGT_LPC);
        cmp("speed", 32'(IOMAD_SPEED_SUBTRACTIVE), 32'(route_speed_out));
        ck(HI, 16'h0800, IOMAD_TGT_LPC);
        diskx_io_cfg_in <= 1'b0;
        ck(HM, 32'h9100_0000, IOMAD_TGT_LPC);
        peer_range_hit_in <= 1'b1;
        ck(PM, 32'h8000_0000, IOMAD_TGT_NONE);
        peer_range_hit_in <= 1'b0;
        fixed_io_hit_in <= 1'b1;
        ck(PI, 16'h0020, IOMAD_TGT_FIXED);
        cmp("speed", 32'(IOMAD_SPEED_MEDIUM), 32'(route_speed_out));
        $display("config gate test done");
        end_of_test();
    end
endmodule
bind iomad_decoder iomad_decoder_assertions chk (.*);
`default_nettype wire
